// [core/pfs_codec_frame.sv]
// Codec-side transmit framing: frame sync detection, power-up mode, time strobe, standby.
// Assumes pins arrive asynchronously; variable-rate bits run on the far side's bit clock.
module pfs_codec_frame #(
    parameter int unsigned POWERUP_CYCLES = pfs_pkg::POWERUP_MCLK_CYCLES,
    parameter int unsigned WORD_BITS      = pfs_pkg::SLOT_BITS
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 tx_bit_clk_i,
    input  wire logic                 transmit_master_clock_i,
    input  wire logic                 transmit_frame_sync_i,
    input  wire logic                 receive_data_clock_select_i,
    input  wire logic                 power_down_pin_n_i,
    input  wire logic [WORD_BITS-1:0] tx_word_i,
    output logic                      tx_data_o,
    output logic                      tx_data_en_o,
    output logic                      tx_var_data_o,
    output logic                      tx_var_en_o,
    output logic                      time_strobe_o,
    output logic                      time_strobe_oe_o,
    output pfs_pkg::pfs_status_t      status_o
);

    localparam int unsigned PU_W   = $clog2(POWERUP_CYCLES + 1);
    localparam int unsigned BIT_W  = $clog2(WORD_BITS + 1);
    localparam int unsigned MISS_W = $clog2(pfs_pkg::MISS_LIMIT_CYCLES + 1);
    localparam logic [PU_W-1:0]   PU_LAST   = PU_W'(POWERUP_CYCLES - 1);
    localparam logic [BIT_W-1:0]  BIT_LAST  = BIT_W'(WORD_BITS - 1);
    localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(pfs_pkg::MISS_LIMIT_CYCLES);

    // Refused at elaboration: the shifters need at least two bits
    if (POWERUP_CYCLES < 1 || WORD_BITS < 2 || WORD_BITS > 16)
    begin : g_param_check
        $error("pfs_codec_frame: unsupported parameter values");
    end

    // System domain: pin synchronisation
    logic [pfs_pkg::SYNC_WIDTH-1:0] pins_s;
    logic                           mclk_s;
    logic                           fs_s;
    logic                           sel_s;
    logic                           pd_active;

    pfs_sync3 #(
        .WIDTH   (pfs_pkg::SYNC_WIDTH),
        .RST_VAL (pfs_pkg::SYNC_RST_VAL)
    ) u_pin_sync (
        .clk_i   (sys_clk_i),
        .nrst_i  (nrst_i),
        .async_i ({power_down_pin_n_i, receive_data_clock_select_i,
                   transmit_frame_sync_i, transmit_master_clock_i}),
        .level_o (pins_s)
    );

    assign mclk_s    = pins_s[pfs_pkg::SYNC_MCLK_POS];
    assign fs_s      = pins_s[pfs_pkg::SYNC_FRAME_POS];
    assign sel_s     = pins_s[pfs_pkg::SYNC_SELECT_POS];
    assign pd_active = ~pins_s[pfs_pkg::SYNC_PWRDN_POS];

    logic mclk_prev_ff;
    logic fs_prev_ff;
    logic mclk_rise;
    logic frame_rise;

    assign mclk_rise  = mclk_s & ~mclk_prev_ff;
    // No filtering: any rising edge, genuine or spurious, opens a frame, except a fixed-mode edge in power-down or a variable-mode edge with standby_ff set
    assign frame_rise = fs_s & ~fs_prev_ff;

    // Mode sequencing
    pfs_pkg::pfs_mode_t state_ff;
    pfs_pkg::pfs_mode_t nxt_state;
    logic [PU_W-1:0]    pu_cnt_ff;
    logic               pu_done;

    assign pu_done = mclk_rise && (pu_cnt_ff == PU_LAST);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            pfs_pkg::PFS_ST_PWRUP:
            begin
                if (pu_done)
                    nxt_state = sel_s ? pfs_pkg::PFS_ST_VAR : pfs_pkg::PFS_ST_FIXED;
            end
            pfs_pkg::PFS_ST_FIXED: nxt_state = pfs_pkg::PFS_ST_FIXED;
            pfs_pkg::PFS_ST_VAR:   nxt_state = pfs_pkg::PFS_ST_VAR;
            default:               nxt_state = pfs_pkg::PFS_ST_PWRUP;
        endcase
        if (pd_active)
            nxt_state = pfs_pkg::PFS_ST_PWRUP;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff     <= pfs_pkg::PFS_ST_PWRUP;
            pu_cnt_ff    <= '0;
            mclk_prev_ff <= 1'b0;
            fs_prev_ff   <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            mclk_prev_ff <= mclk_s;
            fs_prev_ff   <= fs_s;
            if (pd_active || state_ff != pfs_pkg::PFS_ST_PWRUP)
                pu_cnt_ff <= '0;
            else if (mclk_rise && !pu_done)
                pu_cnt_ff <= pu_cnt_ff + 1'b1;
        end
    end

    // Missed frame supervision
    logic [MISS_W-1:0] miss_cnt_ff;
    logic              standby_ff;
    logic              miss_hit;

    assign miss_hit = mclk_rise && (miss_cnt_ff == MISS_LAST);

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            miss_cnt_ff <= '0;
            standby_ff  <= 1'b0;
        end
        else
        begin
            if (frame_rise || pd_active)
                miss_cnt_ff <= '0;
            else if (mclk_rise && !miss_hit)
                miss_cnt_ff <= miss_cnt_ff + 1'b1;
            // A fresh frame edge clears standby_ff at the next clock, too late for that frame's variable-mode hand-off
            if (frame_rise || pd_active)
                standby_ff <= 1'b0;
            else if (miss_hit)
                standby_ff <= 1'b1;
        end
    end

    // Fixed-rate slot: bits leave on master clock edges
    logic                 fixed_mode;
    logic                 slot_start;
    logic                 slot_act_ff;
    logic [BIT_W-1:0]     bit_cnt_ff;
    logic [WORD_BITS-1:0] shreg_ff;

    assign fixed_mode = (state_ff != pfs_pkg::PFS_ST_VAR);
    assign slot_start = frame_rise && fixed_mode && !pd_active;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            slot_act_ff  <= 1'b0;
            bit_cnt_ff   <= '0;
            shreg_ff     <= '0;
            tx_data_o    <= 1'b0;
            tx_data_en_o <= 1'b0;
        end
        else
        begin
            if (slot_start)
            begin
                slot_act_ff <= 1'b1;
                bit_cnt_ff  <= '0;
                shreg_ff    <= tx_word_i;
            end
            else if (slot_act_ff && mclk_rise)
            begin
                tx_data_o  <= shreg_ff[WORD_BITS-1];
                shreg_ff   <= {shreg_ff[WORD_BITS-2:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 1'b1;
                if (bit_cnt_ff == BIT_LAST)
                    slot_act_ff <= 1'b0;
            end
            else if (!fixed_mode || pd_active)
                slot_act_ff <= 1'b0;
            tx_data_en_o <= slot_act_ff && fixed_mode;
        end
    end

    // Strobe pin: open drain, pulls low during the slot while the pin is an output
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            time_strobe_o    <= 1'b1;
            time_strobe_oe_o <= 1'b0;
            status_o         <= pfs_pkg::STATUS_RST;
        end
        else
        begin
            time_strobe_o    <= ~slot_act_ff;
            time_strobe_oe_o <= slot_act_ff && fixed_mode;
            status_o         <= '{standby:       standby_ff,
                                  variable_mode: (state_ff == pfs_pkg::PFS_ST_VAR),
                                  strobe_phase:  fixed_mode};
        end
    end

    // Hand-off of each variable-mode frame's word to the bit clock domain, skipped while standby_ff is set
    logic [WORD_BITS-1:0] word_hold_ff;
    logic                 frame_tgl_ff;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            word_hold_ff <= '0;
            frame_tgl_ff <= 1'b0;
        end
        else if (frame_rise && !fixed_mode && !standby_ff)
        begin
            word_hold_ff <= tx_word_i;
            frame_tgl_ff <= ~frame_tgl_ff;
        end
    end

    // Link domain: the bit clock may stop between frames, so nothing waits on it afterwards
    logic                 tgl_l1_ff;
    logic                 tgl_l2_ff;
    logic                 tgl_seen_ff;
    logic                 fs_l1_ff;
    logic                 fs_l2_ff;
    logic                 var_active_ff;
    logic [BIT_W-1:0]     var_cnt_ff;
    logic [WORD_BITS-1:0] var_word_ff;
    logic [WORD_BITS-1:0] var_shreg_ff;
    logic                 new_frame_l;
    logic                 var_wrap;

    // Word is stable for the whole toggle synchronisation latency
    assign new_frame_l = tgl_l2_ff ^ tgl_seen_ff;
    assign var_wrap    = var_active_ff && (var_cnt_ff == BIT_LAST);

    always_ff @(posedge tx_bit_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tgl_l1_ff     <= 1'b0;
            tgl_l2_ff     <= 1'b0;
            tgl_seen_ff   <= 1'b0;
            fs_l1_ff      <= 1'b0;
            fs_l2_ff      <= 1'b0;
            var_active_ff <= 1'b0;
            var_cnt_ff    <= '0;
            var_word_ff   <= '0;
            var_shreg_ff  <= '0;
            tx_var_data_o <= 1'b0;
            tx_var_en_o   <= 1'b0;
        end
        else
        begin
            tgl_l1_ff   <= frame_tgl_ff;
            tgl_l2_ff   <= tgl_l1_ff;
            tgl_seen_ff <= tgl_l2_ff;
            fs_l1_ff    <= transmit_frame_sync_i;
            fs_l2_ff    <= fs_l1_ff;
            tx_var_en_o <= var_active_ff;
            if (new_frame_l)
            begin
                var_active_ff <= 1'b1;
                var_cnt_ff    <= '0;
                var_word_ff   <= word_hold_ff;
                var_shreg_ff  <= word_hold_ff;
            end
            else if (var_active_ff)
            begin
                tx_var_data_o <= var_shreg_ff[WORD_BITS-1];
                if (var_wrap)
                begin
                    var_cnt_ff    <= '0;
                    var_shreg_ff  <= var_word_ff;
                    var_active_ff <= fs_l2_ff;
                end
                else
                begin
                    var_cnt_ff   <= var_cnt_ff + 1'b1;
                    var_shreg_ff <= {var_shreg_ff[WORD_BITS-2:0], 1'b0};
                end
            end
        end
    end

    // Checks
    sequence s_pu_done;
        state_ff == pfs_pkg::PFS_ST_PWRUP && pu_done && !pd_active;
    endsequence

    frame_edge_slot_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        slot_start |=> slot_act_ff && bit_cnt_ff == '0 ##1 time_strobe_oe_o)
        else $error("frame edge did not open a fixed slot");

    powerdown_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        pd_active |=> state_ff == pfs_pkg::PFS_ST_PWRUP ##1 !status_o.variable_mode)
        else $error("power-down did not return to fixed power-up mode");

    strobe_drive_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        time_strobe_oe_o |-> !time_strobe_o && status_o.strobe_phase)
        else $error("strobe enabled without pulling low in fixed phase");

    var_switch_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_pu_done ##0 sel_s |=> state_ff == pfs_pkg::PFS_ST_VAR ##1 !time_strobe_oe_o)
        else $error("selected variable mode not entered after power-up");

    fixed_stay_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_pu_done ##0 !sel_s |=> state_ff == pfs_pkg::PFS_ST_FIXED)
        else $error("fixed mode not kept with select low");

    var_input_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_ff == pfs_pkg::PFS_ST_VAR [*2] |-> !time_strobe_oe_o)
        else $error("strobe pin driven in variable mode");

    repeat_data_a: assert property (@(posedge tx_bit_clk_i) disable iff (!nrst_i)
        var_wrap && !new_frame_l && fs_l2_ff |=> var_active_ff && var_cnt_ff == '0
            && var_shreg_ff == var_word_ff)
        else $error("word not repeated while frame sync high");

    missed_frame_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        miss_hit && !frame_rise && !pd_active |=> standby_ff ##1 status_o.standby)
        else $error("missed frame sync did not enter standby");

endmodule

// [core/pfs_pkg.sv]
// Shared constants and types for the codec-side frame sync front end.
// Assumes one system clock domain plus a link bit clock supplied by the far side.
package pfs_pkg;

    localparam int unsigned FRAME_MCLK_CYCLES   = 256;
    localparam int unsigned SLOT_BITS           = 8;
    localparam int unsigned POWERUP_MCLK_CYCLES = 16;
    localparam int unsigned MISS_MARGIN_CYCLES  = 8;
    localparam int unsigned MISS_LIMIT_CYCLES   = FRAME_MCLK_CYCLES + MISS_MARGIN_CYCLES;
    localparam int unsigned SYNC_WIDTH          = 4;

    localparam int unsigned SYNC_MCLK_POS       = 0;
    localparam int unsigned SYNC_FRAME_POS      = 1;
    localparam int unsigned SYNC_SELECT_POS     = 2;
    localparam int unsigned SYNC_PWRDN_POS      = 3;
    // Power-down pin resets to its asserted level, frame sync and master clock low
    localparam logic [3:0]  SYNC_RST_VAL        = 4'h0;

    typedef enum logic [1:0] {
        PFS_ST_PWRUP = 2'b00,
        PFS_ST_FIXED = 2'b01,
        PFS_ST_VAR   = 2'b10
    } pfs_mode_t;

    typedef struct packed {
        logic standby;
        logic variable_mode;
        logic strobe_phase;
    } pfs_status_t;

    localparam pfs_status_t STATUS_RST = '{standby: 1'b0, variable_mode: 1'b0, strobe_phase: 1'b1};

endpackage

// [core/pfs_sync3.sv]
// Three-stage synchroniser for pin levels entering the system clock domain.
// Assumes each bit is an independent level; the output moves once stages two and three agree.
module pfs_sync3 #(
    parameter int unsigned     WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] nxt_level;

    assign nxt_level = (s2_ff & s3_ff) | (level_o & (s2_ff ^ s3_ff));

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_ff   <= RST_VAL;
            s2_ff   <= RST_VAL;
            s3_ff   <= RST_VAL;
            level_o <= RST_VAL;
        end
        else
        begin
            s1_ff   <= async_i;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            level_o <= nxt_level;
        end
    end

endmodule

// [bench/pfs_gen_model.sv]
// Behavioural frame sync generator and bit clock source facing the codec.
// Assumes the bench selects short or long sync per codec mode.
module pfs_gen_model (
    input  wire logic rst_n_i,
    input  wire logic en_i,
    input  wire logic glitch_i,
    input  wire logic hold_i,
    output logic      mclk_o,
    output logic      short_fs_o,
    output logic      long_fs_o,
    output logic      late_fs_o,
    output logic      dsp_fs_o,
    output logic      bclk_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Power-on state: the bench reset ends before the first master edge
    logic [3:0] lo_ff  = 4'h0;
    logic [3:0] hi_ff  = 4'h0;
    logic [7:0] dly_ff = 8'h00;
    wire        carry_lo = &lo_ff;
    wire        carry_hi = &hi_ff;
    int         n;

    initial
    begin
        mclk_o = 1'b0;
        forever #244 mclk_o = ~mclk_o;
    end

    // Glitch input stands in for the spike the gate normally hides
    assign short_fs_o = (carry_lo & carry_hi & en_i) | glitch_i;
    assign dsp_fs_o   = short_fs_o;
    assign late_fs_o  = dly_ff[7];

    always @(posedge mclk_o)
    begin
        lo_ff  <= rst_n_i ? lo_ff + 4'h1 : 4'h0;
        hi_ff  <= rst_n_i ? hi_ff + {3'h0, carry_lo} : 4'h0;
        dly_ff <= rst_n_i ? {dly_ff[6:0], short_fs_o} : 8'h00;
    end

    // Bit clock runs a 32-cycle burst from each frame start, idle low otherwise
    initial
    begin
        bclk_o    = 1'b0;
        long_fs_o = 1'b0;
        forever
        begin
            @(posedge mclk_o iff (short_fs_o === 1'b1 && rst_n_i === 1'b1));
            long_fs_o = 1'b1;
            for (n = 0; n < 32; n++)
            begin
                #62.5 bclk_o = 1'b1;
                #62.5 bclk_o = 1'b0;
                if (n == (hold_i ? 23 : 7))
                    long_fs_o = 1'b0;
            end
        end
    end
endmodule

// [bench/pfs_codec_frame_tb.sv]
// Self-checking bench for the codec-side frame sync front end.
// Assumes the generator model drives master clock, syncs and bit clock.
module pfs_codec_frame_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned PWRUP = 4;

    logic                 sys_clk;
    logic                 nrst;
    logic                 sel;
    logic                 pd_n;
    logic                 en;
    logic                 glitch;
    logic                 hold;
    logic [7:0]           word;
    logic                 mclk;
    logic                 short_fs;
    logic                 long_fs;
    logic                 bclk;
    logic                 tx_data;
    logic                 tx_data_en;
    logic                 tx_var_data;
    logic                 tx_var_en;
    logic                 strobe;
    logic                 strobe_oe;
    pfs_pkg::pfs_status_t status;
    int                   error_cnt;
    int                   tests_run;
    int                   cyc;
    wire                  frame_sync = sel ? long_fs : short_fs;

    pfs_gen_model i_pfs_gen_model (
        .rst_n_i    (nrst),
        .en_i       (en),
        .glitch_i   (glitch),
        .hold_i     (hold),
        .mclk_o     (mclk),
        .short_fs_o (short_fs),
        .long_fs_o  (long_fs),
        .late_fs_o  (),
        .dsp_fs_o   (),
        .bclk_o     (bclk)
    );

    // Bit clock drives the codec's tx_bit_clk_i directly, never the strobe pin
    pfs_codec_frame #(.POWERUP_CYCLES(PWRUP), .WORD_BITS(8)) i_pfs_codec_frame (
        .sys_clk_i                   (sys_clk),
        .nrst_i                      (nrst),
        .tx_bit_clk_i                (bclk),
        .transmit_master_clock_i     (mclk),
        .transmit_frame_sync_i       (frame_sync),
        .receive_data_clock_select_i (sel),
        .power_down_pin_n_i          (pd_n),
        .tx_word_i                   (word),
        .tx_data_o                   (tx_data),
        .tx_data_en_o                (tx_data_en),
        .tx_var_data_o               (tx_var_data),
        .tx_var_en_o                 (tx_var_en),
        .time_strobe_o               (strobe),
        .time_strobe_oe_o            (strobe_oe),
        .status_o                    (status)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 20000 && s !== 1'b1; i++)
            @(negedge sys_clk);
    endtask

    // One master rise per bit, strobe pulled low for the whole slot
    task automatic fixed_slot(input logic [7:0] w);
        wait_hi(tx_data_en);
        for (int i = 7; i >= 0; i--)
        begin
            // Slot state just before the rise that launches this bit
            @(posedge mclk);
            @(negedge sys_clk);
            chk(strobe_oe, 1'b1);
            chk(strobe, 1'b0);
            chk(status.strobe_phase, 1'b1);
            @(negedge mclk);
            chk(tx_data, w[i]);
        end
        @(negedge mclk);
        chk(tx_data_en, 1'b0);
    endtask

    task automatic start_fixed();
        repeat (3) @(posedge mclk);
        @(negedge sys_clk);
        pd_n = 1'b1;
        @(posedge mclk);
        repeat (8) @(negedge sys_clk);
        chk(status.variable_mode, 1'b0);
        repeat (PWRUP + 1) @(posedge mclk);
        @(negedge sys_clk);
        en = 1'b1;
        chk(status.variable_mode, 1'b0);
        fixed_slot(8'hA5);
    endtask

    task automatic glitch_frame();
        @(posedge mclk);
        @(negedge sys_clk);
        word   = 8'h5A;
        glitch = 1'b1;
        en     = 1'b0;
        repeat (5) @(negedge sys_clk);
        glitch = 1'b0;
        fixed_slot(8'h5A);
    endtask

    // Rises counted from the spurious edge; standby only after the margin
    task automatic standby_check();
        repeat (252) @(posedge mclk);
        repeat (4) @(negedge sys_clk);
        chk(status.standby, 1'b0);
        repeat (6) @(posedge mclk);
        repeat (4) @(negedge sys_clk);
        chk(status.standby, 1'b1);
        en = 1'b1;
        for (int i = 0; i < 17000 && status.standby !== 1'b0; i++)
            @(negedge sys_clk);
        chk(status.standby, 1'b0);
    endtask

    task automatic var_mode();
        logic [7:0] w;
        w = 8'h3C;
        repeat (2) @(posedge mclk);
        @(negedge sys_clk);
        en = 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge sys_clk);
        pd_n = 1'b0;
        sel  = 1'b1;
        word = w;
        hold = 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge sys_clk);
        pd_n = 1'b1;
        @(posedge mclk);
        repeat (8) @(negedge sys_clk);
        chk(status.variable_mode, 1'b0);
        repeat (PWRUP + 1) @(posedge mclk);
        repeat (4) @(negedge sys_clk);
        chk(status.variable_mode, 1'b1);
        en = 1'b1;
        wait_hi(tx_var_en);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge bclk);
            chk(tx_var_data, w[7 - (i % 8)]);
            chk(tx_var_en, 1'b1);
            chk(status.strobe_phase, 1'b0);
            chk(strobe_oe, 1'b0);
            chk(tx_data_en, 1'b0);
        end
    endtask

    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        cyc       = 0;
        nrst      = 1'b0;
        sel       = 1'b0;
        pd_n      = 1'b0;
        en        = 1'b0;
        glitch    = 1'b0;
        hold      = 1'b0;
        word      = 8'hA5;
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        start_fixed();
        glitch_frame();
        standby_check();
        var_mode();
        test_done();
    end
endmodule
